// ### rtl/mic_irq_ctrl.v
// Our own choice: the strobed register port.
`include "mic_consts.vh"

// Notes on behaviour
// R01 - Accepting any interrupt clears the global enable.
// R02 - Interrupt return instruction sets the global enable.
// R03 - Loading a source's vector clears that source's flag.
// R04 - Masked source still sets its flag; flag held until serviced or cleared.
// R05 - Flags held while global enable is off, then serviced one by one by priority.
// R06 - Low-level external request is not latched; pending only while pin is low.
// R07 - Status register is never saved or restored by hardware.
// R08 - Entry takes four cycles pushing the 9-bit PC, then vector is loaded.
// R09 - A running multicycle instruction completes before entry begins.
// R10 - Entry from sleep takes four extra cycles.
// R11 - Return takes four cycles popping the 9-bit PC.
// R12 - After return, one instruction runs before any pending request is taken.
// R13 - General mask bit 6 with global enable allows external request, vector 001h.
// R14 - External pin activity requests even when the pin is an output.
// R15 - General mask bit 5 enables pin-change request, vector 002h.
// R16 - External flag, bit 6, sets on edge or change; clears on vector or write-one.
// R17 - External flag reads zero in low-level sense mode.
// R18 - Pin-change flag, bit 5, sets on pin event; clears on vector or write-one.
// R19 - Timer mask bit 6 enables compare match, vector 003h.
// R20 - Timer mask bit 2 enables timer-1 overflow, vector 004h.
// R21 - Timer mask bit 1 enables timer-0 overflow, vector 005h.
// R22 - Reserved bits read zero and ignore writes; masks reset to zero.
// R23 - Sense bits: 00 low level, 01 any change, 10 falling, 11 rising.
// R24 - Timer flags at bits 6, 2, 1; clear on vector or write-one.
// R25 - Lowest vector address is serviced first.
// R26 - After reset global enable is zero and all flags are clear.
module mic_irq_ctrl #(
  parameter PC_WIDTH = 6
) (
  input  wire                I_CLK,
  input  wire                I_RST,
  input  wire [7:0]          I_ADDR,
  input  wire [7:0]          I_WDATA,
  input  wire                I_WR,
  input  wire                I_RD,
  output wire [7:0]          O_RDATA,
  input  wire                I_EXT_PIN,
  input  wire [PC_WIDTH-1:0] I_PIN_BUS,
  input  wire                I_T1_COMPARE,
  input  wire                I_T1_OVERFLOW,
  input  wire                I_T0_OVERFLOW,
  input  wire                I_INSTR_DONE,
  input  wire                I_SLEEPING,
  input  wire                I_RETURN,
  output wire                O_CORE_HOLD,
  output wire                O_PC_PUSH,
  output wire                O_PC_POP,
  output wire                O_WAKE,
  output wire                O_VEC_LOAD,
  output wire [8:0]          O_VECTOR,
  output wire                O_GIE
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_WAKE  = 3'h1;
  localparam ST_ENTRY = 3'h2;
  localparam ST_RET   = 3'h3;
  localparam ST_POST  = 3'h4;
  localparam SRC_EXT   = 3'h0;
  localparam SRC_PCHG  = 3'h1;
  localparam SRC_T1CMP = 3'h2;
  localparam SRC_T1OVF = 3'h3;
  localparam SRC_T0OVF = 3'h4;
  //////////////////////////////////////////////////////////////////////////////
  // State and registers
  reg  [2:0]          state_q;
  reg  [2:0]          state_d;
  reg  [2:0]          cnt_q;
  reg  [2:0]          cnt_d;
  reg  [2:0]          src_q;
  reg  [2:0]          src_d;
  reg                 vec_load_q;
  reg  [8:0]          vector_q;
  reg                 gie_q;
  reg                 ext_en_q;
  reg                 pchg_en_q;
  reg                 t1cmp_en_q;
  reg                 t1ovf_en_q;
  reg                 t0ovf_en_q;
  reg                 ext_flag_q;
  reg                 pchg_flag_q;
  reg                 t1cmp_flag_q;
  reg                 t1ovf_flag_q;
  reg                 t0ovf_flag_q;
  reg  [1:0]          sense_q;
  reg  [7:0]          rdata_q;
  reg  [PC_WIDTH:0]   prev_q;
  reg                 armed_q;

  wire [PC_WIDTH:0]   pin_level;
  wire                pin_valid;
  wire                ext_level;
  wire                ext_rise;
  wire                ext_fall;
  wire                ext_event;
  wire                ext_low;
  wire                low_mode;
  wire                pchg_event;
  wire                wr_gflag;
  wire                wr_tflag;
  wire [4:0]          req;
  wire                accept;
  wire                vec_fire;
  wire                ret_done;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling and event detection
  // Pad level is sampled whatever the pin direction, outputs included
  mic_pin_sync #(
    .WIDTH (PC_WIDTH + 1)
  ) u_sync (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_pins  ({I_EXT_PIN, I_PIN_BUS}),  // see R14
    .o_level (pin_level),
    .o_valid (pin_valid)
  );

  always @(posedge I_CLK) begin
    if (I_RST) begin
      prev_q  <= {(PC_WIDTH + 1){1'b0}};
      armed_q <= 1'b0;
    end else begin
      prev_q  <= pin_level;
      armed_q <= pin_valid;
    end
  end

  assign ext_level  = pin_level[PC_WIDTH];
  assign ext_rise   = armed_q & ext_level & ~prev_q[PC_WIDTH];
  assign ext_fall   = armed_q & ~ext_level & prev_q[PC_WIDTH];
  assign low_mode   = (sense_q == `MIC_SENSE_LOW);
  assign ext_low    = pin_valid & ~ext_level;
  // Edge or change selection for the external request
  assign ext_event  = (sense_q == `MIC_SENSE_ANY)  ? (ext_rise | ext_fall) :  // see R23
                      (sense_q == `MIC_SENSE_FALL) ? ext_fall :
                      (sense_q == `MIC_SENSE_RISE) ? ext_rise : 1'b0;

  // Any change on any sampled pin, the external pin included
  assign pchg_event = armed_q & (pin_level != prev_q);  // see R15

  //////////////////////////////////////////////////////////////////////////////
  // Request gating and priority
  assign req[SRC_EXT]   = ext_en_q & (low_mode ? ext_low : ext_flag_q);  // see R13 R06
  assign req[SRC_PCHG]  = pchg_en_q & pchg_flag_q;                       // see R15
  assign req[SRC_T1CMP] = t1cmp_en_q & t1cmp_flag_q;                     // see R19
  assign req[SRC_T1OVF] = t1ovf_en_q & t1ovf_flag_q;                     // see R20
  assign req[SRC_T0OVF] = t0ovf_en_q & t0ovf_flag_q;                     // see R21

  // Taken at an instruction boundary, in idle or once one instruction followed a return
  assign accept = ((state_q == ST_IDLE) | (state_q == ST_POST)) &
                  gie_q & (|req) & I_INSTR_DONE;  // see R05 R09 R12

  function [2:0] pick;
    input [4:0] r;
    integer i;
    begin
      pick = SRC_T0OVF;
      for (i = 4; i >= 0; i = i - 1) begin
        if (r[i]) begin
          pick = i[2:0];  // see R25
        end
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Entry and return sequencer
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    src_d   = src_q;
    case (state_q)
      ST_IDLE, ST_POST: begin
        if (accept) begin
          src_d = pick(req);
          if (I_SLEEPING) begin
            state_d = ST_WAKE;  // see R10
            cnt_d   = `MIC_WAKE_CYCLES - 3'h1;
          end else begin
            state_d = ST_ENTRY;  // see R08
            cnt_d   = `MIC_ENTRY_CYCLES - 3'h1;
          end
        end else if (I_RETURN && state_q == ST_IDLE) begin
          state_d = ST_RET;  // see R11
          cnt_d   = `MIC_RETURN_CYCLES - 3'h1;
        end else if (I_INSTR_DONE) begin
          state_d = ST_IDLE;  // see R12
        end
      end
      ST_WAKE: begin
        if (cnt_q == 3'h0) begin
          state_d = ST_ENTRY;
          cnt_d   = `MIC_ENTRY_CYCLES - 3'h1;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      ST_ENTRY, ST_RET: begin
        if (cnt_q == 3'h0) begin
          state_d = (state_q == ST_RET) ? ST_POST : ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 3'h0;
      end
    endcase
  end

  assign vec_fire = (state_q == ST_ENTRY) & (cnt_q == 3'h0);  // see R08
  assign ret_done = (state_q == ST_RET) & (cnt_q == 3'h0);

  // The status register is left alone on entry and return
  always @(posedge I_CLK) begin  // see R07
    if (I_RST) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 3'h0;
      src_q      <= SRC_EXT;
      vec_load_q <= 1'b0;
      vector_q   <= 9'h000;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      src_q      <= src_d;
      vec_load_q <= vec_fire;
      if (vec_fire) begin
        vector_q <= {6'h00, src_q} + 9'h001;  // see R13 R15 R19 R20 R21
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and flags
  assign wr_gflag = I_WR & (I_ADDR == `MIC_OFF_GFLAG);
  assign wr_tflag = I_WR & (I_ADDR == `MIC_OFF_TFLAG);

  always @(posedge I_CLK) begin
    if (I_RST) begin
      gie_q      <= `MIC_RST_GIE;  // see R26
      ext_en_q   <= 1'b0;          // see R22
      pchg_en_q  <= 1'b0;
      t1cmp_en_q <= 1'b0;
      t1ovf_en_q <= 1'b0;
      t0ovf_en_q <= 1'b0;
      sense_q    <= `MIC_RST_SENSE;
    end else begin
      if (I_WR && I_ADDR == `MIC_OFF_GMASK) begin
        ext_en_q  <= I_WDATA[`MIC_BIT_EXT];
        pchg_en_q <= I_WDATA[`MIC_BIT_PCHG];
      end
      if (I_WR && I_ADDR == `MIC_OFF_TMASK) begin
        t1cmp_en_q <= I_WDATA[`MIC_BIT_T1CMP];
        t1ovf_en_q <= I_WDATA[`MIC_BIT_T1OVF];
        t0ovf_en_q <= I_WDATA[`MIC_BIT_T0OVF];
      end
      if (I_WR && I_ADDR == `MIC_OFF_SENSE) begin
        sense_q <= {I_WDATA[`MIC_BIT_SENSE_HI], I_WDATA[`MIC_BIT_SENSE_LO]};
      end
      // Hardware takes precedence over a software write in the same cycle
      if (accept) begin
        gie_q <= 1'b0;  // see R01
      end else if (ret_done) begin
        gie_q <= 1'b1;  // see R02
      end else if (I_WR && I_ADDR == `MIC_OFF_GCTRL) begin
        gie_q <= I_WDATA[`MIC_BIT_GIE];
      end
    end
  end

  // Each flag: a new event wins over a clear arriving in the same cycle
  always @(posedge I_CLK) begin
    if (I_RST) begin
      ext_flag_q   <= 1'b0;  // see R26
      pchg_flag_q  <= 1'b0;
      t1cmp_flag_q <= 1'b0;
      t1ovf_flag_q <= 1'b0;
      t0ovf_flag_q <= 1'b0;
    end else begin
      if (low_mode) begin
        ext_flag_q <= 1'b0;  // see R06 R17
      end else if (ext_event) begin
        ext_flag_q <= 1'b1;  // see R16 R04
      end else if ((vec_fire && src_q == SRC_EXT) ||
                   (wr_gflag && I_WDATA[`MIC_BIT_EXT])) begin
        ext_flag_q <= 1'b0;  // see R03 R16
      end
      if (pchg_event) begin
        pchg_flag_q <= 1'b1;  // see R18 R04
      end else if ((vec_fire && src_q == SRC_PCHG) ||
                   (wr_gflag && I_WDATA[`MIC_BIT_PCHG])) begin
        pchg_flag_q <= 1'b0;  // see R03 R18
      end
      if (I_T1_COMPARE) begin
        t1cmp_flag_q <= 1'b1;  // see R24 R04
      end else if ((vec_fire && src_q == SRC_T1CMP) ||
                   (wr_tflag && I_WDATA[`MIC_BIT_T1CMP])) begin
        t1cmp_flag_q <= 1'b0;  // see R03 R24
      end
      if (I_T1_OVERFLOW) begin
        t1ovf_flag_q <= 1'b1;  // see R24 R04
      end else if ((vec_fire && src_q == SRC_T1OVF) ||
                   (wr_tflag && I_WDATA[`MIC_BIT_T1OVF])) begin
        t1ovf_flag_q <= 1'b0;  // see R03 R24
      end
      if (I_T0_OVERFLOW) begin
        t0ovf_flag_q <= 1'b1;  // see R24 R04
      end else if ((vec_fire && src_q == SRC_T0OVF) ||
                   (wr_tflag && I_WDATA[`MIC_BIT_T0OVF])) begin
        t0ovf_flag_q <= 1'b0;  // see R03 R24
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe
  always @(posedge I_CLK) begin
    rdata_q <= 8'h00;  // see R22
    if (I_RD && !I_RST) begin
      case (I_ADDR)
        `MIC_OFF_GMASK: begin
          rdata_q[`MIC_BIT_EXT]  <= ext_en_q;
          rdata_q[`MIC_BIT_PCHG] <= pchg_en_q;
        end
        `MIC_OFF_GFLAG: begin
          rdata_q[`MIC_BIT_EXT]  <= ext_flag_q & ~low_mode;  // see R17
          rdata_q[`MIC_BIT_PCHG] <= pchg_flag_q;
        end
        `MIC_OFF_TMASK: begin
          rdata_q[`MIC_BIT_T1CMP] <= t1cmp_en_q;
          rdata_q[`MIC_BIT_T1OVF] <= t1ovf_en_q;
          rdata_q[`MIC_BIT_T0OVF] <= t0ovf_en_q;
        end
        `MIC_OFF_TFLAG: begin
          rdata_q[`MIC_BIT_T1CMP] <= t1cmp_flag_q;
          rdata_q[`MIC_BIT_T1OVF] <= t1ovf_flag_q;
          rdata_q[`MIC_BIT_T0OVF] <= t0ovf_flag_q;
        end
        `MIC_OFF_SENSE: begin
          rdata_q[`MIC_BIT_SENSE_HI:`MIC_BIT_SENSE_LO] <= sense_q;
        end
        `MIC_OFF_GCTRL: begin
          rdata_q[`MIC_BIT_GIE] <= gie_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign O_RDATA     = rdata_q;
  assign O_CORE_HOLD = (state_q == ST_WAKE) | (state_q == ST_ENTRY) | (state_q == ST_RET);
  assign O_PC_PUSH   = (state_q == ST_ENTRY);  // see R08
  assign O_PC_POP    = (state_q == ST_RET);    // see R11
  assign O_WAKE      = (state_q == ST_WAKE);   // see R10
  assign O_VEC_LOAD  = vec_load_q;
  assign O_VECTOR    = vector_q;
  assign O_GIE       = gie_q;

endmodule // mic_irq_ctrl

// ### rtl/mic_consts.vh
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define MIC_OFF_TFLAG     8'h38
`define MIC_OFF_TMASK     8'h39
`define MIC_OFF_GFLAG     8'h3a
`define MIC_OFF_GMASK     8'h3b
`define MIC_OFF_SENSE     8'h35
`define MIC_OFF_GCTRL     8'h30

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define MIC_BIT_EXT       6
`define MIC_BIT_PCHG      5
`define MIC_BIT_T1CMP     6
`define MIC_BIT_T1OVF     2
`define MIC_BIT_T0OVF     1
`define MIC_BIT_GIE       7
`define MIC_BIT_SENSE_HI  1
`define MIC_BIT_SENSE_LO  0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MIC_RST_MASK      8'h00
`define MIC_RST_FLAGS     8'h00
`define MIC_RST_SENSE     2'h0
`define MIC_RST_GIE       1'b0

////////////////////////////////////////////////////////////////////////////////
// Sense modes
`define MIC_SENSE_LOW     2'h0
`define MIC_SENSE_ANY     2'h1
`define MIC_SENSE_FALL    2'h2
`define MIC_SENSE_RISE    2'h3

////////////////////////////////////////////////////////////////////////////////
// Vector addresses, lowest first
`define MIC_VEC_EXT       9'h001
`define MIC_VEC_PCHG      9'h002
`define MIC_VEC_T1CMP     9'h003
`define MIC_VEC_T1OVF     9'h004
`define MIC_VEC_T0OVF     9'h005

////////////////////////////////////////////////////////////////////////////////
// Timing counts in clock cycles
`define MIC_ENTRY_CYCLES  3'h4
`define MIC_WAKE_CYCLES   3'h4
`define MIC_RETURN_CYCLES 3'h4

`endif

// ### rtl/mic_pin_sync.v
module mic_pin_sync #(
  parameter WIDTH = 7
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_pins,
  output wire [WIDTH-1:0] o_level,
  output wire             o_valid
);

  reg [1:0] fill_q;
  reg       valid_q;

  // Counts the cycles until the third stage holds a real sample
  always @(posedge i_clk) begin
    if (i_rst) begin
      fill_q  <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      if (fill_q != 2'h3) begin
        fill_q <= fill_q + 2'h1;
      end
      if (fill_q == 2'h3) begin
        valid_q <= 1'b1;
      end
    end
  end

  assign o_valid = valid_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // Level moves only once the second and third stages agree
      always @(posedge i_clk) begin
        if (i_rst) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= i_pins[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (fill_q == 2'h3 && s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate

endmodule // mic_pin_sync

// ### verif/mic_irq_ctrl_checker.sv
module mic_irq_ctrl_checker (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       I_RD,
  input wire logic       I_INSTR_DONE,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_CORE_HOLD,
  input wire logic       O_PC_PUSH,
  input wire logic       O_PC_POP,
  input wire logic       O_WAKE,
  input wire logic       O_VEC_LOAD,
  input wire logic [8:0] O_VECTOR,
  input wire logic       O_GIE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////
  chk_entry_gie: assert property ((O_PC_PUSH || O_WAKE) |-> !O_GIE)
    else $error("global enable high during entry");
  chk_push_len: assert property ($rose(O_PC_PUSH) |-> O_PC_PUSH [*4] ##1 (!O_PC_PUSH && O_VEC_LOAD))
    else $error("entry push length wrong");
  chk_pop_len: assert property ($rose(O_PC_POP) |-> O_PC_POP [*4] ##1 (!O_PC_POP && O_GIE))
    else $error("return pop length wrong");
  chk_wake_len: assert property ($rose(O_WAKE) |-> O_WAKE [*4] ##1 (!O_WAKE && O_PC_PUSH))
    else $error("wake stretch wrong");
  chk_accept_bound: assert property ($rose(O_PC_PUSH) && !$past(O_WAKE) |-> $past(I_INSTR_DONE))
    else $error("entry away from instruction boundary");
  chk_ret_one_instr: assert property ($fell(O_PC_POP) |-> !O_PC_PUSH && !O_WAKE)
    else $error("entry too soon after return");
  chk_vec_range: assert property (O_VEC_LOAD |-> O_VECTOR inside {[9'h001:9'h005]})
    else $error("vector out of range");
  chk_vec_hold: assert property (!O_VEC_LOAD |-> $stable(O_VECTOR))
    else $error("vector moved without load");
  chk_hold_map: assert property (O_CORE_HOLD == (O_WAKE || O_PC_PUSH || O_PC_POP))
    else $error("core hold mismatch");
  chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_gie_reset: assert property ($fell(I_RST) |-> !O_GIE)
    else $error("global enable set after reset");
  cov_entry: cover property ($rose(O_VEC_LOAD));
  cov_return: cover property ($rose(O_PC_POP));
  cov_wake: cover property ($rose(O_WAKE));
endmodule // mic_irq_ctrl_checker

// ### verif/mic_core_model.sv
module mic_core_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  input  wire logic i_sleep,
  input  wire logic i_hold,
  input  wire logic i_vec_load,
  input  wire logic i_wake,
  output logic      o_done,
  output logic      o_sleeping,
  output logic      o_ret
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [3:0] isr_q;
  ////////////////////////////////////////
  // Slow mode runs three-cycle instructions
  assign o_done = !i_hold && (cnt_q == (i_slow ? 2'h2 : 2'h0));
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q      <= 2'h0;
      isr_q      <= 4'h0;
      o_ret      <= 1'b0;
      o_sleeping <= 1'b0;
    end else begin
      cnt_q      <= (i_hold || o_done) ? 2'h0 : cnt_q + 2'h1;
      o_ret      <= (isr_q == 4'h1) && o_done;
      o_sleeping <= i_sleep ? 1'b1 : (i_wake ? 1'b0 : o_sleeping);
      // Handler body of a few instructions, the last one returns
      if (i_vec_load) begin
        isr_q <= 4'h6;
      end else if (o_done && isr_q != 4'h0) begin
        isr_q <= isr_q - 4'h1;
      end
    end
  end
endmodule // mic_core_model

// ### verif/mic_irq_ctrl_tb_top.sv
module mic_irq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} mic_row_t;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ext = 1'b1;
  logic       slow = 1'b0, slp = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [2:0] tmr = 3'h0;
  logic [5:0] pins = 6'h00;
  wire  [7:0] rdata;
  wire  [8:0] vec;
  wire        hold, push, pop, wake, vload, gie, done, sleeping, ret;
  int         failures = 0;
  int         samples_checked = 0;
  mic_row_t   rows [7] = '{'{8'h39, 8'hff, 8'h46}, '{8'h3b, 8'hff, 8'h60},
    '{8'h35, 8'hff, 8'h03}, '{8'h30, 8'h7f, 8'h00}, '{8'h38, 8'hff, 8'h00},
    '{8'h3a, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}};
  // Sense mode, start level, end level, expected external flag
  logic [4:0] srows [6] = '{5'b11011, 5'b11100, 5'b10101, 5'b10010, 5'b01101, 5'b01011};
  always #25 clk = ~clk;
  mic_irq_ctrl #(.PC_WIDTH(6)) u_mic_irq_ctrl (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EXT_PIN(ext), .I_PIN_BUS(pins),
    .I_T1_COMPARE(tmr[2]), .I_T1_OVERFLOW(tmr[1]), .I_T0_OVERFLOW(tmr[0]), .I_INSTR_DONE(done),
    .I_SLEEPING(sleeping), .I_RETURN(ret), .O_CORE_HOLD(hold), .O_PC_PUSH(push), .O_PC_POP(pop),
    .O_WAKE(wake), .O_VEC_LOAD(vload), .O_VECTOR(vec), .O_GIE(gie));
  mic_core_model u_mic_core_model (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_sleep(slp),
    .i_hold(hold), .i_vec_load(vload), .i_wake(wake), .o_done(done), .o_sleeping(sleeping),
    .o_ret(ret));
  ////////////////////////////////////////
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check({2'h0, rdata}, {2'h0, e});
    @(posedge clk);
  endtask
  task automatic pulse(input logic [2:0] m);
    tmr <= m;
    @(posedge clk);
    tmr <= 3'h0;
  endtask
  // Waits for the vector load and checks it together with the cleared enable
  task automatic vec_is(input logic [8:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vload !== 1'b1 && n < 200);
    check({vload, vec}, {1'b1, v});
    check({9'h0, gie}, 10'h0);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    check({9'h0, gie}, 10'h0);
    @(posedge clk);
    foreach (rows[i]) begin
      rdchk(rows[i].a, 8'h00);
      wreg(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    wreg(8'h39, 8'h00);
    wreg(8'h3b, 8'h00);
    pulse(3'h7);
    rdchk(8'h38, 8'h46);
    wreg(8'h38, 8'h44);
    rdchk(8'h38, 8'h02);
    pulse(3'h6);
    wreg(8'h39, 8'h46);
    wreg(8'h30, 8'h80);
    vec_is(9'h003);
    wait (pop === 1'b1);
    @(negedge clk iff (pop === 1'b0));
    check({9'h0, push}, 10'h0);
    @(negedge clk);
    check({9'h0, push}, 10'h1);
    vec_is(9'h004);
    vec_is(9'h005);
    repeat (20) @(negedge clk);
    check({9'h0, gie}, 10'h1);
    @(posedge clk);
    rdchk(8'h38, 8'h00);
    wreg(8'h39, 8'h00);
    foreach (srows[i]) begin
      ext <= srows[i][2];
      repeat (8) @(posedge clk);
      wreg(8'h3a, 8'hff);
      wreg(8'h35, {6'h0, srows[i][4:3]});
      ext <= srows[i][1];
      repeat (8) @(posedge clk);
      rdchk(8'h3a, {1'b0, srows[i][0], 6'h20});
    end
    wreg(8'h30, 8'h00);
    wreg(8'h35, 8'h03);
    wreg(8'h3b, 8'h60);
    ext <= 1'b0;
    repeat (8) @(posedge clk);
    wreg(8'h3a, 8'hff);
    ext <= 1'b1;
    repeat (8) @(posedge clk);
    wreg(8'h30, 8'h80);
    vec_is(9'h001);
    vec_is(9'h002);
    repeat (20) @(posedge clk);
    wreg(8'h3b, 8'h20);
    pins <= 6'h20;
    vec_is(9'h002);
    repeat (20) @(posedge clk);
    wreg(8'h3b, 8'h40);
    wreg(8'h35, 8'h00);
    ext <= 1'b0;
    vec_is(9'h001);
    ext <= 1'b1;
    repeat (20) @(posedge clk);
    rdchk(8'h3a, 8'h20);
    wreg(8'h3b, 8'h00);
    wreg(8'h39, 8'h02);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    repeat (3) @(posedge clk);
    pulse(3'h1);
    vec_is(9'h005);
    repeat (20) @(posedge clk);
    slow <= 1'b1;
    pulse(3'h1);
    vec_is(9'h005);
    repeat (30) @(posedge clk);
    slow <= 1'b0;
    wreg(8'h39, 8'h00);
    pulse(3'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({9'h0, gie}, 10'h0);
    @(posedge clk);
    rdchk(8'h38, 8'h00);
    rdchk(8'h3b, 8'h00);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule // mic_irq_ctrl_tb_top

bind mic_irq_ctrl mic_irq_ctrl_checker u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_RD(I_RD),
  .I_INSTR_DONE(I_INSTR_DONE), .O_RDATA(O_RDATA), .O_CORE_HOLD(O_CORE_HOLD),
  .O_PC_PUSH(O_PC_PUSH), .O_PC_POP(O_PC_POP), .O_WAKE(O_WAKE), .O_VEC_LOAD(O_VEC_LOAD),
  .O_VECTOR(O_VECTOR), .O_GIE(O_GIE));
